// >>> common/radio_uart_pkg.sv
// Functional notes
// R1 - serial input carries both configuration command bytes and payload bytes
// R2 - select low marks received bytes as commands, high marks them as payload
// R3 - serial output carries command responses and payload received over the air
// R4 - clear-to-send output high while busy, low when ready for more data
// R5 - reply indicator low while the outgoing byte is a command response
// R6 - input-drained flag high when the serial input buffer is empty
// R7 - fault alert output goes high on an exception whose mask bit is set
// R8 - reading the fault status register returns the fault alert output low
// R9 - host starts no new byte while clear-to-send is high
package radio_uart_pkg;

    localparam int          CLK_HZ      = 125_000_000;
    localparam int          BAUD_HZ     = 115_200;
    localparam logic [15:0] DIV_DEFAULT = 16'(CLK_HZ / BAUD_HZ);
    localparam logic [15:0] DIV_MIN     = 16'h0004;

    // byte addresses, one aligned 32-bit word each
    localparam logic [7:0] OFS_DIVISOR = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_RX_DATA = 8'h08;
    localparam logic [7:0] OFS_TX_DATA = 8'h0c;
    localparam logic [7:0] OFS_FAULT   = 8'h10;
    localparam logic [7:0] OFS_MASK    = 8'h14;
    localparam logic [7:0] OFS_CTRL    = 8'h18;

    // fault status / mask layout
    localparam int          EV_W        = 3;
    localparam int          EV_OVERRUN  = 0;
    localparam int          EV_FRAMING  = 1;
    localparam int          EV_COLLIDE  = 2;
    localparam logic [2:0]  MASK_RESET  = 3'h0;

    // status layout
    localparam int ST_RX_FULL = 0;
    localparam int ST_RX_CMD  = 1;
    localparam int ST_TX_BUSY = 2;
    localparam int ST_CTS_N   = 3;
    localparam int ST_REPLY   = 4;
    localparam int ST_KIND    = 5;

    // data word layout
    localparam int RXD_PAYLOAD = 8;
    localparam int RXD_VALID   = 9;
    localparam int TXD_RESP    = 8;

    // control layout
    localparam int         CTL_ENABLE = 0;
    localparam int         CTL_HOLD   = 1;
    localparam logic [1:0] CTL_RESET  = 2'h1;

    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } rx_fsm_t;

    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA  = 4'b0100,
        TX_STOP  = 4'b1000
    } tx_fsm_t;

    typedef struct packed {
        logic       valid;
        logic       frame_err;
        logic [7:0] data;
    } rx_byte_t;

    typedef struct packed {
        rx_fsm_t    fsm;
        logic [15:0] cnt;
        logic [2:0]  bit_idx;
        logic [7:0]  shift;
        rx_byte_t    out;
    } rx_state_t;

    typedef struct packed {
        logic        rx_meta;
        logic        rx_sync;
        logic        kind_meta;
        logic        kind_sync;
        tx_fsm_t     tx_fsm;
        logic [15:0] tx_cnt;
        logic [2:0]  tx_bit;
        logic [7:0]  tx_shift;
        logic        tx_pend;
        logic        tx_pend_resp;
        logic [7:0]  tx_pend_data;
        logic        buf_full;
        logic        buf_cmd;
        logic [7:0]  buf_data;
        logic [15:0] divisor;
        logic [1:0]  ctrl;
        logic [2:0]  fault;
        logic [2:0]  mask;
        logic        alert;
        logic        irq;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        tx_pin;
        logic        cts_n;
        logic        reply;
        logic        drained;
    } top_state_t;

endpackage

// >>> dv/host_uart_model.sv
module host_uart_model #(
    parameter int BIT = 8
)
(
    input  wire logic pclk,
    output logic      serial_rx,
    input  wire logic serial_tx,
    input  wire logic clear_to_send_n,
    input  wire logic reply_indicator
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got;
    logic       got_reply;
    int         n_got = 0;

    initial serial_rx = 1'b1;

    // rude skips the flow-control wait, only to provoke an overrun
    task automatic send(input logic [7:0] b, input logic rude);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        while (clear_to_send_n !== 1'b0 && !rude) @(posedge pclk);
        for (int i = 0; i < 10; i++) begin
            serial_rx <= f[i];
            repeat (BIT) @(posedge pclk);
        end
    endtask

    always begin
        @(negedge serial_tx);
        repeat (BIT / 2) @(posedge pclk);
        got_reply = reply_indicator;
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge pclk);
            got[i] = serial_tx;
        end
        repeat (BIT) @(posedge pclk);
        n_got++;
    end
endmodule // host_uart_model

// >>> dv/radio_uart_sideband_asserts.sv
module radio_uart_sideband_asserts
    import radio_uart_pkg::*;
#(
    parameter logic [15:0] DIV_RESET = DIV_DEFAULT
)
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        serial_rx,
    input wire logic        serial_tx,
    input wire logic        frame_kind,
    input wire logic        clear_to_send_n,
    input wire logic        reply_indicator,
    input wire logic        input_drained_flag,
    input wire logic        fault_alert_line
);
    // a pending byte may wait behind a full frame in flight
    localparam int TX_WAIT = 21 * DIV_RESET;
    logic done;
    logic tx_owed;
    int   tx_wait;
    assign done = psel && penable && pready;

    // long frames make a delay range too deep, so the wait is counted instead
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_owed <= 1'b0;
            tx_wait <= 0;
        end else if (done && pwrite && paddr == OFS_TX_DATA) begin
            tx_owed <= 1'b1;
            tx_wait <= 0;
        end else if ($fell(serial_tx)) begin
            tx_owed <= 1'b0;
            tx_wait <= 0;
        end else if (tx_owed) begin
            tx_wait <= tx_wait + 1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    apb_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    apb_err_a: assert property (done && paddr > OFS_CTRL |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    busy_full_a: assert property (!input_drained_flag |-> clear_to_send_n)
        else $error("ready while byte held");
    fill_busy_a: assert property ($fell(input_drained_flag) |-> $rose(clear_to_send_n))
        else $error("busy not raised with byte arrival");
    pop_empty_a: assert property (done && !pwrite && paddr == OFS_RX_DATA |=> input_drained_flag)
        else $error("drained flag not set after pop");
    reply_start_a: assert property ($fell(reply_indicator) |-> $fell(serial_tx))
        else $error("reply low outside start bit");
    reply_hold_a: assert property ($fell(reply_indicator) |=> !reply_indicator [*8])
        else $error("reply dropped within first bit");
    alert_set_a: assert property ($rose(fault_alert_line) |-> ##[0:1] irq)
        else $error("alert without masked fault");
    alert_clr_a: assert property (done && !pwrite && paddr == OFS_FAULT |=> !fault_alert_line)
        else $error("alert kept after fault read");
    tx_go_a: assert property (tx_wait <= TX_WAIT)
        else $error("written byte never started");
endmodule // radio_uart_sideband_asserts

bind radio_uart_sideband radio_uart_sideband_asserts #(.DIV_RESET(DIV_RESET)) i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .serial_rx(serial_rx),
    .serial_tx(serial_tx), .frame_kind(frame_kind), .clear_to_send_n(clear_to_send_n),
    .reply_indicator(reply_indicator), .input_drained_flag(input_drained_flag),
    .fault_alert_line(fault_alert_line)
);

// >>> dv/radio_uart_sideband_tb.sv
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end

module radio_uart_sideband_tb
    import radio_uart_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] DIV = 16'h0008;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, frame_kind = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, irq, err, serial_rx, serial_tx;
    logic        clear_to_send_n, reply_indicator, input_drained_flag, fault_alert_line;
    int          fails = 0, n_checks = 0;

    always #4 pclk = ~pclk;

    radio_uart_sideband #(.DIV_RESET(DIV)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .serial_rx(serial_rx), .serial_tx(serial_tx), .frame_kind(frame_kind),
        .clear_to_send_n(clear_to_send_n), .reply_indicator(reply_indicator),
        .input_drained_flag(input_drained_flag), .fault_alert_line(fault_alert_line)
    );

    host_uart_model #(.BIT(8)) i_host (
        .pclk(pclk), .serial_rx(serial_rx), .serial_tx(serial_tx),
        .clear_to_send_n(clear_to_send_n), .reply_indicator(reply_indicator)
    );

    // one idle cycle in front keeps release and next setup in different steps
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    task automatic summarize;
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic t_reset;
        `CHK(clear_to_send_n, 1'b0)
        rdchk(OFS_DIVISOR, {16'h0, DIV});
        rdchk(OFS_MASK, 32'h0);
        rdchk(OFS_CTRL, 32'h1);
        rdchk(8'h1c, 32'h0);
        `CHK(err, 1'b1)
    endtask

    task automatic t_rx;
        logic [7:0] b;
        for (int k = 0; k < 2; k++) begin
            b = k ? 8'h3c : 8'ha5;
            frame_kind <= k[0];
            i_host.send(b, 1'b0);
            repeat (4) @(posedge pclk);
            `CHK({clear_to_send_n, input_drained_flag}, 2'b10)
            rdchk(OFS_RX_DATA, {22'h0, 1'b1, k[0], b});
            @(negedge pclk);
            `CHK({clear_to_send_n, input_drained_flag}, 2'b01)
        end
    endtask

    task automatic t_tx;
        int n0;
        for (int k = 0; k < 2; k++) begin
            n0 = i_host.n_got;
            apb(1'b1, OFS_TX_DATA, {23'h0, k[0], 8'hc6 ^ 8'(k)});
            for (int w = 0; w < 200 && i_host.n_got == n0; w++) @(posedge pclk);
            if (i_host.n_got == n0) fails++;
            `CHK(i_host.got, 8'hc6 ^ 8'(k))
            `CHK(i_host.got_reply, ~k[0])
        end
    endtask

    task automatic t_fault;
        frame_kind <= 1'b0;
        apb(1'b1, OFS_TX_DATA, 32'h11);
        apb(1'b1, OFS_TX_DATA, 32'h22);
        apb(1'b1, OFS_TX_DATA, 32'h33);
        @(negedge pclk);
        `CHK({fault_alert_line, irq}, 2'b00)
        rdchk(OFS_FAULT, 32'h4);
        apb(1'b1, OFS_FAULT, 32'h4);
        apb(1'b1, OFS_MASK, 32'h1);
        i_host.send(8'h77, 1'b0);
        i_host.send(8'h88, 1'b1);
        repeat (4) @(posedge pclk);
        `CHK({fault_alert_line, irq}, 2'b11)
        rdchk(OFS_FAULT, 32'h1);
        @(negedge pclk);
        `CHK({fault_alert_line, irq}, 2'b01)
        apb(1'b1, OFS_FAULT, 32'h1);
        @(negedge pclk);
        `CHK(irq, 1'b0)
        rdchk(OFS_RX_DATA, 32'h277);
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        `CHK({serial_tx, clear_to_send_n, reply_indicator, input_drained_flag, fault_alert_line}, 5'h1e)
        presetn <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        t_reset;
        t_rx;
        t_tx;
        t_fault;
        summarize;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        summarize;
    end
endmodule // radio_uart_sideband_tb

// >>> hdl/radio_uart_sideband.sv
// Decided for this implementation: the APB register port and the address map.
module radio_uart_sideband
    import radio_uart_pkg::*;
#(
    parameter logic [15:0] DIV_RESET = DIV_DEFAULT
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        serial_rx,
    output logic             serial_tx,
    input  wire logic        frame_kind,
    output logic             clear_to_send_n,
    output logic             reply_indicator,
    output logic             input_drained_flag,
    output logic             fault_alert_line
);

    if (DIV_RESET < DIV_MIN) begin : g_bad_divisor
        $error("divisor default below the receiver's minimum");
    end

    top_state_t s;
    top_state_t next_s;
    rx_byte_t   rx_byte;

    // rx pin passes the two synchroniser flops before reaching the receiver
    serial_byte_receiver u_receiver (
        .pclk     (pclk),
        .presetn  (presetn),
        .line_in  (s.rx_sync),
        .divisor  (s.divisor),
        .byte_out (rx_byte)
    );

    logic        access;
    logic        done;
    logic [2:0]  events;
    logic [31:0] rd_word;
    logic        rd_err;

    always_comb begin
        next_s = s;
        events = 3'h0;
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        access = psel && penable;
        done = access && s.pready;

        next_s.rx_meta = serial_rx;
        next_s.rx_sync = s.rx_meta;
        next_s.kind_meta = frame_kind;
        next_s.kind_sync = s.kind_meta;

        // receive path: both kinds of byte arrive on the one input [R1]
        if (rx_byte.valid && s.ctrl[CTL_ENABLE]) begin
            if (rx_byte.frame_err) begin
                events[EV_FRAMING] = 1'b1;
            end else if (s.buf_full) begin
                // only reachable when the host ignored clear-to-send [R9]
                events[EV_OVERRUN] = 1'b1;
            end else begin
                next_s.buf_full = 1'b1;
                next_s.buf_data = rx_byte.data;
                // kind taken at the stop bit, select low means command [R2]
                next_s.buf_cmd = !s.kind_sync;
            end
        end

        // transmit path serves replies and over-the-air payload alike [R3]
        case (s.tx_fsm)
            TX_IDLE: begin
                next_s.tx_pin = 1'b1;
                if (s.tx_pend) begin
                    next_s.tx_fsm = TX_START;
                    next_s.tx_pin = 1'b0;
                    next_s.tx_cnt = s.divisor - 16'h0001;
                    next_s.tx_shift = s.tx_pend_data;
                    next_s.tx_pend = 1'b0;
                    next_s.reply = !s.tx_pend_resp; // [R5]
                end
            end
            TX_START: begin
                if (s.tx_cnt == 16'h0000) begin
                    next_s.tx_fsm = TX_DATA;
                    next_s.tx_pin = s.tx_shift[0];
                    next_s.tx_shift = s.tx_shift >> 1;
                    next_s.tx_bit = 3'h0;
                    next_s.tx_cnt = s.divisor - 16'h0001;
                end else begin
                    next_s.tx_cnt = s.tx_cnt - 16'h0001;
                end
            end
            TX_DATA: begin
                if (s.tx_cnt == 16'h0000) begin
                    next_s.tx_cnt = s.divisor - 16'h0001;
                    if (s.tx_bit == LAST_BIT) begin
                        next_s.tx_fsm = TX_STOP;
                        next_s.tx_pin = 1'b1;
                    end else begin
                        next_s.tx_pin = s.tx_shift[0];
                        next_s.tx_shift = s.tx_shift >> 1;
                        next_s.tx_bit = s.tx_bit + 3'h1;
                    end
                end else begin
                    next_s.tx_cnt = s.tx_cnt - 16'h0001;
                end
            end
            TX_STOP: begin
                if (s.tx_cnt == 16'h0000) begin
                    next_s.tx_fsm = TX_IDLE;
                    // stays low only for the bytes of a response [R5]
                    next_s.reply = 1'b1;
                end else begin
                    next_s.tx_cnt = s.tx_cnt - 16'h0001;
                end
            end
            default: begin
                next_s.tx_fsm = TX_IDLE;
                next_s.tx_pin = 1'b1;
            end
        endcase

        // read word and decode for the access phase
        if (paddr == OFS_DIVISOR) begin
            rd_word[15:0] = s.divisor;
        end else if (paddr == OFS_STATUS) begin
            rd_word[ST_RX_FULL] = s.buf_full;
            rd_word[ST_RX_CMD]  = s.buf_cmd;
            rd_word[ST_TX_BUSY] = (s.tx_fsm != TX_IDLE) || s.tx_pend;
            rd_word[ST_CTS_N]   = s.cts_n;
            rd_word[ST_REPLY]   = s.reply;
            rd_word[ST_KIND]    = s.kind_sync;
        end else if (paddr == OFS_RX_DATA) begin
            rd_word[7:0]         = s.buf_data;
            rd_word[RXD_PAYLOAD] = !s.buf_cmd;
            rd_word[RXD_VALID]   = s.buf_full;
        end else if (paddr == OFS_TX_DATA) begin
            rd_word[7:0]      = s.tx_pend_data;
            rd_word[TXD_RESP] = s.tx_pend_resp;
        end else if (paddr == OFS_FAULT) begin
            rd_word[EV_W-1:0] = s.fault;
        end else if (paddr == OFS_MASK) begin
            rd_word[EV_W-1:0] = s.mask;
        end else if (paddr == OFS_CTRL) begin
            rd_word[1:0] = s.ctrl;
        end else begin
            rd_err = 1'b1;
        end

        // one wait state: ready rises in the second access cycle
        next_s.pready = access && !s.pready;
        if (access && !s.pready) begin
            next_s.prdata = pwrite ? 32'h0000_0000 : rd_word;
            next_s.pslverr = rd_err;
        end else if (!access) begin
            next_s.pslverr = 1'b0;
        end

        // register side effects happen only at the completing edge
        if (done && pwrite) begin
            if (paddr == OFS_DIVISOR) begin
                // too small a divisor cannot centre the receiver's sample
                if (pwdata[15:0] >= DIV_MIN) begin
                    next_s.divisor = pwdata[15:0];
                end
            end else if (paddr == OFS_TX_DATA) begin
                if (s.tx_pend) begin
                    events[EV_COLLIDE] = 1'b1;
                end else begin
                    next_s.tx_pend = 1'b1;
                    next_s.tx_pend_data = pwdata[7:0];
                    next_s.tx_pend_resp = pwdata[TXD_RESP];
                end
            end else if (paddr == OFS_FAULT) begin
                next_s.fault = s.fault & ~pwdata[EV_W-1:0];
            end else if (paddr == OFS_MASK) begin
                next_s.mask = pwdata[EV_W-1:0];
            end else if (paddr == OFS_CTRL) begin
                next_s.ctrl = pwdata[1:0];
            end
        end else if (done) begin
            if (paddr == OFS_RX_DATA) begin
                next_s.buf_full = 1'b0;
            end else if (paddr == OFS_FAULT) begin
                next_s.alert = 1'b0; // [R8]
            end
        end

        // a byte landing in an empty buffer stays held despite a pop in the same cycle
        if (rx_byte.valid && s.ctrl[CTL_ENABLE] && !rx_byte.frame_err && !s.buf_full) begin
            next_s.buf_full = 1'b1;
        end

        // new events win over a clear in the same cycle
        next_s.fault = next_s.fault | events;
        if ((events & s.mask) != 3'h0) begin
            next_s.alert = 1'b1; // [R7]
        end
        next_s.irq = (next_s.fault & next_s.mask) != 3'h0;

        // busy while the byte is held, disabled or held off by software
        next_s.cts_n = next_s.buf_full || !next_s.ctrl[CTL_ENABLE] || next_s.ctrl[CTL_HOLD]; // [R4]
        next_s.drained = !next_s.buf_full; // [R6]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.rx_meta      <= 1'b1;
            s.rx_sync      <= 1'b1;
            s.kind_meta    <= 1'b0;
            s.kind_sync    <= 1'b0;
            s.tx_fsm       <= TX_IDLE;
            s.tx_cnt       <= 16'h0000;
            s.tx_bit       <= 3'h0;
            s.tx_shift     <= 8'h00;
            s.tx_pend      <= 1'b0;
            s.tx_pend_resp <= 1'b0;
            s.tx_pend_data <= 8'h00;
            s.buf_full     <= 1'b0;
            s.buf_cmd      <= 1'b0;
            s.buf_data     <= 8'h00;
            s.divisor      <= DIV_RESET;
            s.ctrl         <= CTL_RESET;
            s.fault        <= 3'h0;
            s.mask         <= MASK_RESET;
            s.alert        <= 1'b0;
            s.irq          <= 1'b0;
            s.prdata       <= 32'h0000_0000;
            s.pready       <= 1'b0;
            s.pslverr      <= 1'b0;
            s.tx_pin       <= 1'b1;
            s.cts_n        <= 1'b1;
            s.reply        <= 1'b1;
            s.drained      <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata             = s.prdata;
    assign pready             = s.pready;
    assign pslverr            = s.pslverr;
    assign irq                = s.irq;
    assign serial_tx          = s.tx_pin;
    assign clear_to_send_n    = s.cts_n;
    assign reply_indicator    = s.reply;
    assign input_drained_flag = s.drained;
    assign fault_alert_line   = s.alert;

endmodule // radio_uart_sideband

// >>> hdl/serial_byte_receiver.sv
module serial_byte_receiver
    import radio_uart_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        line_in,
    input  wire logic [15:0] divisor,
    output rx_byte_t         byte_out
);

    rx_state_t s;
    rx_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.out.valid = 1'b0;
        next_s.out.frame_err = 1'b0;
        case (s.fsm)
            RX_IDLE: begin
                if (!line_in) begin
                    next_s.fsm = RX_START;
                    next_s.cnt = divisor >> 1;
                end
            end
            RX_START: begin
                if (s.cnt == 16'h0000) begin
                    // a start bit gone by mid-bit is noise
                    if (line_in) begin
                        next_s.fsm = RX_IDLE;
                    end else begin
                        next_s.fsm = RX_DATA;
                        next_s.cnt = divisor - 16'h0001;
                        next_s.bit_idx = 3'h0;
                    end
                end else begin
                    next_s.cnt = s.cnt - 16'h0001;
                end
            end
            RX_DATA: begin
                if (s.cnt == 16'h0000) begin
                    next_s.shift = {line_in, s.shift[7:1]};
                    next_s.cnt = divisor - 16'h0001;
                    if (s.bit_idx == LAST_BIT) begin
                        next_s.fsm = RX_STOP;
                    end else begin
                        next_s.bit_idx = s.bit_idx + 3'h1;
                    end
                end else begin
                    next_s.cnt = s.cnt - 16'h0001;
                end
            end
            RX_STOP: begin
                if (s.cnt == 16'h0000) begin
                    next_s.fsm = RX_IDLE;
                    next_s.out.valid = 1'b1;
                    next_s.out.frame_err = !line_in;
                    next_s.out.data = s.shift;
                end else begin
                    next_s.cnt = s.cnt - 16'h0001;
                end
            end
            default: begin
                next_s.fsm = RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{fsm: RX_IDLE, cnt: 16'h0000, bit_idx: 3'h0, shift: 8'h00,
                   out: '{valid: 1'b0, frame_err: 1'b0, data: 8'h00}};
        end else begin
            s <= next_s;
        end
    end

    assign byte_out = s.out;

endmodule // serial_byte_receiver
